// ==== rtl/pmwc_pkg.sv ====
// Package of constants and types for the power mode and wake controller
package pmwc_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] PMWC_OFF_MODE_REQ = 8'h00;
    localparam logic [7:0] PMWC_OFF_WAKE_CFG = 8'h04;
    localparam logic [7:0] PMWC_OFF_STATE = 8'h08;
    localparam logic [7:0] PMWC_OFF_CAUSE = 8'h0c;
    localparam logic [7:0] PMWC_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] PMWC_OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] PMWC_OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] PMWC_OFF_CLK_SEL = 8'h1c;
    localparam logic [7:0] PMWC_OFF_WAKE_TIME = 8'h20;
    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int PMWC_REQ_GO_BIT = 3;
    localparam int PMWC_CFG_TMR_EN_BIT = 0;
    localparam int PMWC_CFG_PIN_EN_BIT = 1;
    localparam int PMWC_IRQ_WAKE_BIT = 0;
    localparam int PMWC_IRQ_ENTER_BIT = 1;
    localparam int PMWC_IRQ_CLKSW_BIT = 2;
    localparam logic [1:0] PMWC_CFG_RST = 2'h3;
    localparam logic [1:0] PMWC_CLK_SEL_RST = 2'h0;
    localparam logic [31:0] PMWC_WAKE_TIME_RST = 32'h0000_0020;
    // Idle bus clock runs at one pulse in this many cycles
    localparam logic [3:0] PMWC_IDLE_DIV = 4'h4;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PMWC_MODE_ACTIVE = 3'h0,
        PMWC_MODE_IDLE = 3'h1,
        PMWC_MODE_SLEEP = 3'h2,
        PMWC_MODE_PDS = 3'h3,
        PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP = 3'h4,
        PMWC_MODE_OFF = 3'h5
    } pmwc_mode_t;

    typedef enum logic [1:0] {
        PMWC_SRC_LP_OSC = 2'h0,
        PMWC_SRC_HA_OSC = 2'h1,
        PMWC_SRC_EXT = 2'h2
    } pmwc_src_t;

    typedef enum logic [1:0] {
        PMWC_CAUSE_NONE = 2'h0,
        PMWC_CAUSE_TIMER = 2'h1,
        PMWC_CAUSE_PIN = 2'h2
    } pmwc_cause_t;
endpackage

// ==== rtl/pmwc_clk_mux.sv ====
// Glitch-free switch between three slow clock source levels
`timescale 1ns/1ns
`default_nettype none
module pmwc_clk_mux
    import pmwc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_src,
    input wire logic [1:0] i_sel,
    output logic o_clk,
    output logic [1:0] o_active,
    output logic o_switched
);
    logic [1:0] cur_q;
    logic [1:0] pend_q;
    logic wait_q;
    logic prev_q;

    // ---------------------------------------------------------------
    // Change source only when both old and new levels are low
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_q <= PMWC_CLK_SEL_RST;
            pend_q <= PMWC_CLK_SEL_RST;
            wait_q <= 1'b0;
            o_switched <= 1'b0;
        end else begin
            o_switched <= 1'b0;
            if (!wait_q && i_sel != cur_q && i_sel <= 2'h2) begin
                pend_q <= i_sel;
                wait_q <= 1'b1;
            end else if (wait_q && !i_src[cur_q] && !i_src[pend_q] && !prev_q) begin
                cur_q <= pend_q;
                wait_q <= 1'b0;
                o_switched <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b0;
            o_clk <= 1'b0;
        end else begin
            prev_q <= i_src[cur_q];
            o_clk <= wait_q ? (i_src[cur_q] & prev_q) : i_src[cur_q];
        end
    end

    assign o_active = cur_q;
endmodule
`default_nettype wire

// ==== rtl/pmwc_top.sv ====
// Power mode sequencer, wake control and slow clock selection
`timescale 1ns/1ns
`default_nettype none
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int WAKE_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_wake_pin,
    input wire logic i_low_power_internal_osc,
    input wire logic i_high_accuracy_internal_osc,
    input wire logic i_external_slow_crystal,
    input wire logic i_periph_busy,
    output logic o_cpu_run,
    output logic o_periph_en,
    output logic o_bus_clk_en,
    output logic o_periph_clk_en,
    output logic o_low_freq_clock,
    output logic o_reg_low_volt,
    output logic o_core_pwr,
    output logic o_retain_pwr,
    output logic o_ram_pwr,
    output logic o_radio_pwr,
    output logic o_reg_pwr,
    output logic o_osc_en,
    output logic o_rtc_en,
    output logic o_fw_init,
    output logic o_irq
);
    pmwc_mode_t mode_q;
    logic [1:0] cfg_q;
    logic [1:0] clk_sel_q;
    logic [WAKE_W-1:0] wake_time_q;
    logic [WAKE_W-1:0] cnt_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    pmwc_cause_t cause_q;
    logic from_off_q;
    logic pin_q;
    logic [3:0] div_q;
    logic slow_tick_q;
    logic [1:0] src_active;
    logic mux_clk;
    logic sw_evt;
    logic wr_en;
    logic rd_en;
    logic sleeping;
    logic tmr_hit;
    logic pin_hit;
    logic wake;
    logic req_go;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && i_penable && !i_pwrite;
    assign sleeping = mode_q inside {PMWC_MODE_SLEEP, PMWC_MODE_PDS, PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP,
                                     PMWC_MODE_OFF};
    assign tmr_hit = sleeping && cfg_q[PMWC_CFG_TMR_EN_BIT] && cnt_q >= wake_time_q;
    assign pin_hit = sleeping && cfg_q[PMWC_CFG_PIN_EN_BIT] && i_wake_pin && !pin_q;
    assign wake = tmr_hit || pin_hit;
    assign req_go = wr_en && i_paddr == PMWC_OFF_MODE_REQ && i_pwdata[PMWC_REQ_GO_BIT];

    // ---------------------------------------------------------------
    // Slow clock source selection
    // ---------------------------------------------------------------
    pmwc_clk_mux u_mux (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_src({i_external_slow_crystal, i_high_accuracy_internal_osc,
                i_low_power_internal_osc}),
        .i_sel(clk_sel_q),
        .o_clk(mux_clk),
        .o_active(src_active),
        .o_switched(sw_evt)
    );

    // ---------------------------------------------------------------
    // Mode sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= PMWC_MODE_ACTIVE;
        end else if (wake) begin
            mode_q <= PMWC_MODE_ACTIVE;
        end else if (req_go && !sleeping) begin
            // Only firmware starts a low power entry
            unique case (i_pwdata[2:0])
                3'h0: mode_q <= PMWC_MODE_ACTIVE;
                3'h1: mode_q <= PMWC_MODE_IDLE;
                3'h2: mode_q <= PMWC_MODE_SLEEP;
                3'h3: mode_q <= PMWC_MODE_PDS;
                3'h4: mode_q <= PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP;
                3'h5: mode_q <= PMWC_MODE_OFF;
                default: mode_q <= mode_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Wake timer and pin edge
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            pin_q <= 1'b0;
        end else begin
            pin_q <= i_wake_pin;
            if (!sleeping || wake) begin
                cnt_q <= '0;
            end else if (cnt_q != wake_time_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Wake cause record, kept outside the core domain
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cause_q <= PMWC_CAUSE_NONE;
            from_off_q <= 1'b0;
        end else if (wake) begin
            cause_q <= tmr_hit ? PMWC_CAUSE_TIMER : PMWC_CAUSE_PIN;
            from_off_q <= mode_q == PMWC_MODE_OFF;
        end else if (wr_en && i_paddr == PMWC_OFF_CAUSE) begin
            cause_q <= PMWC_CAUSE_NONE;
            from_off_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Idle bus clock divider
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= '0;
            slow_tick_q <= 1'b0;
        end else begin
            slow_tick_q <= div_q == PMWC_IDLE_DIV - 4'h1;
            div_q <= (div_q == PMWC_IDLE_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Power and clock outputs
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_run <= 1'b1;
            o_periph_en <= 1'b1;
            o_bus_clk_en <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_reg_low_volt <= 1'b0;
            o_core_pwr <= 1'b1;
            o_retain_pwr <= 1'b1;
            o_ram_pwr <= 1'b1;
            o_radio_pwr <= 1'b1;
            o_reg_pwr <= 1'b1;
            o_osc_en <= 1'b1;
            o_rtc_en <= 1'b1;
            o_low_freq_clock <= 1'b0;
        end else begin
            o_cpu_run <= mode_q == PMWC_MODE_ACTIVE;
            o_periph_en <= !sleeping;
            unique case (mode_q)
                PMWC_MODE_ACTIVE: o_bus_clk_en <= 1'b1;
                PMWC_MODE_IDLE: o_bus_clk_en <= slow_tick_q;
                default: o_bus_clk_en <= 1'b0;
            endcase
            o_periph_clk_en <= !sleeping ||
                               (mode_q == PMWC_MODE_SLEEP && i_periph_busy);
            o_reg_low_volt <= mode_q inside {PMWC_MODE_SLEEP, PMWC_MODE_PDS,
                                             PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP};
            o_core_pwr <= !(mode_q inside {PMWC_MODE_PDS, PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP,
                                           PMWC_MODE_OFF});
            o_retain_pwr <= !(mode_q inside {PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP, PMWC_MODE_OFF});
            o_ram_pwr <= mode_q != PMWC_MODE_OFF;
            o_radio_pwr <= !(mode_q inside {PMWC_MODE_PDS, PMWC_MODE_EXTENDED_POWER_DOWN_SLEEP,
                                            PMWC_MODE_OFF});
            o_reg_pwr <= mode_q != PMWC_MODE_OFF;
            o_osc_en <= mode_q != PMWC_MODE_OFF;
            o_rtc_en <= mode_q != PMWC_MODE_OFF;
            o_low_freq_clock <= (mode_q != PMWC_MODE_OFF) && mux_clk;
        end
    end

    // Full firmware start after leaving deep-off
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fw_init <= 1'b0;
        end else begin
            o_fw_init <= wake && mode_q == PMWC_MODE_OFF;
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= PMWC_CFG_RST;
            clk_sel_q <= PMWC_CLK_SEL_RST;
            wake_time_q <= WAKE_W'(PMWC_WAKE_TIME_RST);
            irq_en_q <= '0;
        end else if (wr_en) begin
            unique case (i_paddr)
                PMWC_OFF_WAKE_CFG: cfg_q <= i_pwdata[1:0];
                PMWC_OFF_CLK_SEL: clk_sel_q <= i_pwdata[1:0];
                PMWC_OFF_WAKE_TIME: wake_time_q <= i_pwdata[WAKE_W-1:0];
                PMWC_OFF_IRQ_EN: irq_en_q <= i_pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ---------------------------------------------------------------
    assign irq_set = {sw_evt, req_go && !sleeping, wake};
    assign irq_clr = (wr_en && i_paddr == PMWC_OFF_IRQ_CLR) ? i_pwdata[2:0] : 3'h0;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_q <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            o_irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // ---------------------------------------------------------------
    // APB read path, zero wait states
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= '0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_pslverr <= !(i_paddr inside {PMWC_OFF_MODE_REQ, PMWC_OFF_WAKE_CFG,
                    PMWC_OFF_STATE, PMWC_OFF_CAUSE, PMWC_OFF_IRQ_STAT, PMWC_OFF_IRQ_EN,
                    PMWC_OFF_IRQ_CLR, PMWC_OFF_CLK_SEL, PMWC_OFF_WAKE_TIME});
                unique case (i_paddr)
                    PMWC_OFF_MODE_REQ: o_prdata <= {29'h0, mode_q};
                    PMWC_OFF_WAKE_CFG: o_prdata <= {30'h0, cfg_q};
                    PMWC_OFF_STATE: o_prdata <= {26'h0, src_active, 1'b0, mode_q};
                    PMWC_OFF_CAUSE: o_prdata <= {29'h0, from_off_q, cause_q};
                    PMWC_OFF_IRQ_STAT: o_prdata <= {29'h0, irq_stat_q};
                    PMWC_OFF_IRQ_EN: o_prdata <= {29'h0, irq_en_q};
                    PMWC_OFF_CLK_SEL: o_prdata <= {30'h0, clk_sel_q};
                    PMWC_OFF_WAKE_TIME: o_prdata <= 32'(wake_time_q);
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/pmwc_top_monitor.sv ====
// Concurrent checks on the power mode and wake controller ports
`timescale 1ns/1ns
`default_nettype none
module pmwc_monitor
    import pmwc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic i_periph_busy,
    input wire logic o_pready,
    input wire logic o_cpu_run,
    input wire logic o_periph_en,
    input wire logic o_bus_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_low_freq_clock,
    input wire logic o_reg_low_volt,
    input wire logic o_core_pwr,
    input wire logic o_retain_pwr,
    input wire logic o_ram_pwr,
    input wire logic o_radio_pwr,
    input wire logic o_reg_pwr,
    input wire logic o_osc_en,
    input wire logic o_rtc_en,
    input wire logic o_fw_init
);
    default clocking mon_cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ---------------------------------------------------------------
    // Sequences
    // ---------------------------------------------------------------
    sequence off_exit_s;
        !o_ram_pwr ##1 o_ram_pwr;
    endsequence
    sequence fw_pulse_s;
        o_fw_init ##1 !o_fw_init;
    endsequence
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    run_clocks_a: assert property (o_cpu_run |-> o_bus_clk_en && o_periph_en && o_periph_clk_en)
        else $error("active mode without clocks");
    idle_div_a: assert property (o_periph_en && !o_cpu_run && o_bus_clk_en
        |=> (!o_bus_clk_en || o_cpu_run) [*3]) else $error("idle bus clock too fast");
    sleep_stop_a: assert property (o_reg_low_volt |-> !o_cpu_run && !o_bus_clk_en && !o_periph_en)
        else $error("clocks running in sleep");
    periph_gate_a: assert property (o_reg_low_volt && o_core_pwr && $past(o_reg_low_volt)
        |-> o_periph_clk_en == $past(i_periph_busy)) else $error("peripheral clock gating wrong");
    pds_power_a: assert property (o_reg_low_volt && !o_core_pwr
        |-> !o_radio_pwr && !o_periph_clk_en && o_ram_pwr && o_reg_pwr) else $error("pds power wrong");
    extended_power_down_sleep_power_a: assert property (!o_retain_pwr && o_ram_pwr |-> !o_core_pwr && o_reg_low_volt)
        else $error("extended power-down wrong");
    off_power_a: assert property (!o_ram_pwr |-> !o_core_pwr && !o_radio_pwr && !o_retain_pwr
        && !o_reg_pwr && !o_osc_en && !o_rtc_en && !o_low_freq_clock) else $error("deep-off power wrong");
    fw_init_a: assert property (off_exit_s |-> ($past(o_fw_init) || o_fw_init) or ##[1:2] o_fw_init)
        else $error("no init pulse after deep-off");
    fw_once_a: assert property (o_fw_init |-> fw_pulse_s) else $error("init pulse too long");
    entry_req_a: assert property ($rose(o_reg_low_volt) || $fell(o_ram_pwr)
        |-> $past(i_psel && i_penable && i_pwrite && i_paddr == PMWC_OFF_MODE_REQ, 2))
        else $error("low power entry without request");
    apb_ready_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready");
endmodule
bind pmwc_top pmwc_monitor mon_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_periph_busy(i_periph_busy),
    .o_pready(o_pready), .o_cpu_run(o_cpu_run), .o_periph_en(o_periph_en),
    .o_bus_clk_en(o_bus_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_low_freq_clock(o_low_freq_clock), .o_reg_low_volt(o_reg_low_volt),
    .o_core_pwr(o_core_pwr), .o_retain_pwr(o_retain_pwr), .o_ram_pwr(o_ram_pwr),
    .o_radio_pwr(o_radio_pwr), .o_reg_pwr(o_reg_pwr), .o_osc_en(o_osc_en),
    .o_rtc_en(o_rtc_en), .o_fw_init(o_fw_init)
);
`default_nettype wire

// ==== testbench/test_power_mode_wake_control.sv ====
// Self-checking bench for the power mode and wake controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_power_mode_wake_control
    import pmwc_pkg::*;
;
    logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_wake_pin = 0;
    logic i_low_power_internal_osc = 0, i_high_accuracy_internal_osc = 0;
    logic i_external_slow_crystal = 0, i_periph_busy = 0, prev;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rnd = 32'hf7270023;
    logic o_pready, o_pslverr, o_cpu_run, o_periph_en, o_bus_clk_en, o_periph_clk_en;
    logic o_low_freq_clock, o_reg_low_volt, o_core_pwr, o_retain_pwr, o_ram_pwr, o_radio_pwr;
    logic o_reg_pwr, o_osc_en, o_rtc_en, o_fw_init, o_irq, fw_seen = 0, tmr;
    logic [33:0] exq[$], e;
    logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [31:0] rv[9] = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h20};
    int n_fail = 0, checks_done = 0, cyc = 0, per[3] = '{6, 10, 14}, srt[3] = '{1, 2, 0};
    int m, n, t0, wt, k;

    pmwc_top #(.WAKE_W(32)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_wake_pin(i_wake_pin),
        .i_low_power_internal_osc(i_low_power_internal_osc),
        .i_high_accuracy_internal_osc(i_high_accuracy_internal_osc),
        .i_external_slow_crystal(i_external_slow_crystal), .i_periph_busy(i_periph_busy),
        .o_cpu_run(o_cpu_run), .o_periph_en(o_periph_en), .o_bus_clk_en(o_bus_clk_en),
        .o_periph_clk_en(o_periph_clk_en), .o_low_freq_clock(o_low_freq_clock),
        .o_reg_low_volt(o_reg_low_volt), .o_core_pwr(o_core_pwr),
        .o_retain_pwr(o_retain_pwr), .o_ram_pwr(o_ram_pwr), .o_radio_pwr(o_radio_pwr),
        .o_reg_pwr(o_reg_pwr), .o_osc_en(o_osc_en), .o_rtc_en(o_rtc_en),
        .o_fw_init(o_fw_init), .o_irq(o_irq)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    initial forever #5 i_clk = ~i_clk;

    // ---------------------------------------------------------------
    // Slow sources of three rates and random peripheral load
    // ---------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        i_low_power_internal_osc <= (cyc % 6) < 3;
        i_high_accuracy_internal_osc <= (cyc % 10) < 5;
        i_external_slow_crystal <= (cyc % 14) < 7;
        rnd <= lfsr(rnd);
        i_periph_busy <= rnd[3];
    end

    // ---------------------------------------------------------------
    // Result watcher
    // ---------------------------------------------------------------
    always @(negedge i_clk) begin
        if (o_fw_init) fw_seen = 1;
        if (i_psel && i_penable && o_pready && exq.size() > 0) begin
            e = exq.pop_front();
            if (e[33]) `CHK("read data", e[31:0], o_prdata)
            `CHK("slave error", e[32], o_pslverr)
        end
    end

    task automatic results;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] x);
        int c;
        c = 0;
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        exq.push_back(x);
        @(posedge i_clk);
        i_penable <= 1;
        do begin @(negedge i_clk); c++; end while (!o_pready && c < 50);
        if (!o_pready) begin n_fail++; results(); end
        @(posedge i_clk);
        i_psel <= 0;
        i_penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d, 34'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(0, a, 32'h0, {2'b10, d});
    endtask

    task automatic settle(int c);
        repeat (c) @(negedge i_clk);
    endtask

    initial begin
        settle(1);
        `CHK("reset run", 1'b1, o_cpu_run)
        `CHK("reset irq", 1'b0, o_irq)
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1;
        for (k = 0; k < 9; k++) rd(ra[k], rv[k]);
        apb(0, 8'h24, 32'h0, {2'b11, 32'h0});
        apb(1, 8'h24, 32'h5, {2'b01, 32'h0});
        $display("test reset done");
        wr(PMWC_OFF_MODE_REQ, 32'h9);
        settle(2);
        `CHK("idle run", 1'b0, o_cpu_run)
        `CHK("idle periph", 1'b1, o_periph_en)
        n = 0;
        repeat (16) begin settle(1); n += o_bus_clk_en; end
        `CHK("idle pulses", 4, n)
        rd(PMWC_OFF_MODE_REQ, 32'h1);
        wr(PMWC_OFF_MODE_REQ, 32'h8);
        wr(PMWC_OFF_MODE_REQ, 32'he);
        rd(PMWC_OFF_MODE_REQ, 32'h0);
        settle(2);
        `CHK("active run", 1'b1, o_cpu_run)
        $display("test idle done");
        for (m = 2; m <= 5; m++) begin
            tmr = (m % 2) == 0;
            wt = 24 + int'(rnd[3:0]);
            wr(PMWC_OFF_WAKE_TIME, wt);
            wr(PMWC_OFF_WAKE_CFG, tmr ? 32'h1 : 32'h2);
            wr(PMWC_OFF_IRQ_EN, 32'h1);
            wr(PMWC_OFF_MODE_REQ, 32'h8 | m);
            t0 = cyc;
            settle(3);
            `CHK("core", m < 3, o_core_pwr)
            `CHK("retain", m < 4, o_retain_pwr)
            `CHK("ram", m < 5, o_ram_pwr)
            `CHK("low volt", m < 5, o_reg_low_volt)
            `CHK("rtc", m < 5, o_rtc_en)
            `CHK("radio", m < 3, o_radio_pwr)
            `CHK("bus clk", 1'b0, o_bus_clk_en)
            wr(PMWC_OFF_MODE_REQ, 32'h8);
            `CHK("refused", 1'b0, o_cpu_run)
            if (!tmr) begin
                settle(2 * wt);
                `CHK("still off", 1'b0, o_cpu_run)
                @(posedge i_clk) i_wake_pin <= 1;
            end
            n = 0;
            while (!o_cpu_run && n < 400) begin settle(1); n++; end
            if (tmr) `CHK("wake time", 1'b1, cyc - t0 >= wt && cyc - t0 <= wt + 3)
            `CHK("woken", 1'b1, o_cpu_run)
            if (!o_cpu_run) results();
            @(posedge i_clk) i_wake_pin <= 0;
            settle(2);
            `CHK("wake irq", 1'b1, o_irq)
            rd(PMWC_OFF_CAUSE, (m == 5 ? 32'h4 : 32'h0) | (tmr ? 32'h1 : 32'h2));
            if (m == 5) `CHK("init pulse", 1'b1, fw_seen)
            wr(PMWC_OFF_IRQ_EN, 32'h0);
            settle(2);
            `CHK("masked irq", 1'b0, o_irq)
            wr(PMWC_OFF_IRQ_CLR, 32'h7);
            wr(PMWC_OFF_IRQ_EN, 32'h1);
            settle(2);
            `CHK("cleared irq", 1'b0, o_irq)
            wr(PMWC_OFF_CAUSE, 32'h0);
            rd(PMWC_OFF_CAUSE, 32'h0);
            fw_seen = 0;
            $display("test low power mode %0d done", m);
        end
        wr(PMWC_OFF_IRQ_EN, 32'h4);
        for (k = 0; k < 3; k++) begin
            wr(PMWC_OFF_CLK_SEL, srt[k]);
            settle(40);
            n = 0;
            prev = o_low_freq_clock;
            repeat (140) begin
                settle(1);
                if (o_low_freq_clock && !prev) n++;
                prev = o_low_freq_clock;
            end
            `CHK("edges", 1'b1, n >= 140 / per[srt[k]] - 1 && n <= 140 / per[srt[k]] + 1)
            `CHK("switch irq", 1'b1, o_irq)
            rd(PMWC_OFF_STATE, srt[k] << 4);
            wr(PMWC_OFF_IRQ_CLR, 32'h4);
        end
        wr(PMWC_OFF_CLK_SEL, 32'h3);
        rd(PMWC_OFF_CLK_SEL, 32'h3);
        rd(PMWC_OFF_STATE, 32'h0);
        $display("test clock select done");
        results();
    end
endmodule
`default_nettype wire
